/* File: hdl/imrr_pkg.sv */
// package: register map, field layout and state carriers of the input mixer routing bank
package imrr_pkg;

   // ------------
   // bus geometry
   // ------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned REG_W  = 16;

   // ------------
   // register offsets
   // ------------
   localparam logic [7:0] OFS_PIN_SEL = 8'h28;
   localparam logic [7:0] OFS_LMIX    = 8'h29;
   localparam logic [7:0] OFS_RMIX    = 8'h2A;

   // ------------
   // pin select field positions
   // ------------
   localparam int unsigned SEL_L2P = 7;
   localparam int unsigned SEL_L2N = 6;
   localparam int unsigned SEL_L1P = 5;
   localparam int unsigned SEL_L1N = 4;
   localparam int unsigned SEL_R2P = 3;
   localparam int unsigned SEL_R2N = 2;
   localparam int unsigned SEL_R1P = 1;
   localparam int unsigned SEL_R1N = 0;

   // ------------
   // record mixer field positions
   // ------------
   localparam int unsigned MIX_A2_UNMUTE = 8;
   localparam int unsigned MIX_A2_BOOST  = 7;
   localparam int unsigned MIX_A1_UNMUTE = 5;
   localparam int unsigned MIX_A1_BOOST  = 4;
   localparam int unsigned MIX_FB_LSB    = 0;
   localparam int unsigned MIX_FB_W      = 3;

   // ------------
   // implemented bits and reset values
   // ------------
   localparam logic [15:0]         SEL_MASK    = 16'h00FF;
   localparam logic [15:0]         MIX_MASK    = 16'h01B7;
   localparam logic [MIX_FB_W-1:0] FB_MUTE     = 3'h0;
   localparam logic [15:0]         RST_RDATA   = 16'h0000;
   localparam logic                RST_FB_MUTE = 1'b1;
   localparam logic                RST_REF     = 1'b0;

   // amplifier input connections, one bit each
   typedef struct packed {
      logic left_amp_two_pos_select;
      logic left_amp_two_neg_select;
      logic left_amp_one_pos_select;
      logic left_amp_one_neg_select;
      logic right_amp_two_pos_select;
      logic right_amp_two_neg_select;
      logic right_amp_one_pos_select;
      logic right_amp_one_neg_select;
   } imrr_route_t;

   // one record mixer's input controls
   typedef struct packed {
      logic                amp_two_mix_unmute;
      logic                amp_two_mix_boost;
      logic                amp_one_mix_unmute;
      logic                amp_one_mix_boost;
      logic [MIX_FB_W-1:0] feedback_gain;
   } imrr_mix_t;

   // whole state of the bank
   typedef struct packed {
      imrr_route_t route;
      imrr_mix_t   lmix;
      imrr_mix_t   rmix;
      logic        lfb_mute;
      logic        rfb_mute;
      logic        ref_need;
      logic [15:0] rdata;
   } imrr_state_t;

   localparam imrr_route_t RST_ROUTE = 8'h00;
   localparam imrr_mix_t   RST_MIX   = 7'h00;

endpackage

/* File: hdl/imrr_regs.sv */
// input mixer routing register bank driving the record path front end
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns

module imrr_regs #(
   parameter int unsigned ADDR_W = imrr_pkg::ADDR_W
) (
   // clock, reset, enable
   input  wire logic                 core_clk,
   input  wire logic                 sys_rst,
   input  wire logic                 core_ce,
   // register port
   input  wire logic [ADDR_W-1:0]    reg_addr,
   input  wire logic [15:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output      logic [15:0]          reg_rdata,
   // amplifier input routing
   output      imrr_pkg::imrr_route_t amp_route,
   // record mixer controls
   output      imrr_pkg::imrr_mix_t  left_record_mixer,
   output      imrr_pkg::imrr_mix_t  right_record_mixer,
   output      logic                 left_feedback_mute,
   output      logic                 right_feedback_mute,
   // status towards the reference buffer
   output      logic                 reference_buffer_needed
);

   // ------------
   // decode helpers
   // ------------

   // address match, offsets widened to the port width
   function automatic logic hit(
      input logic [ADDR_W-1:0] a,
      input logic [7:0]        ofs
   );
      hit = (a == ADDR_W'(ofs));
   endfunction

   // any of the three bank addresses
   function automatic logic mapped(
      input logic [ADDR_W-1:0] a
   );
      mapped = hit(a, imrr_pkg::OFS_PIN_SEL) | hit(a, imrr_pkg::OFS_LMIX)
             | hit(a, imrr_pkg::OFS_RMIX);
   endfunction

   // pin select word to connections; upper byte is dropped
   function automatic imrr_pkg::imrr_route_t route_from_word(
      input logic [15:0] w
   );
      imrr_pkg::imrr_route_t r;
      r = imrr_pkg::RST_ROUTE;
      r.left_amp_two_pos_select  = w[imrr_pkg::SEL_L2P];
      r.left_amp_two_neg_select  = w[imrr_pkg::SEL_L2N];
      r.left_amp_one_pos_select  = w[imrr_pkg::SEL_L1P];
      r.left_amp_one_neg_select  = w[imrr_pkg::SEL_L1N];
      r.right_amp_two_pos_select = w[imrr_pkg::SEL_R2P];
      r.right_amp_two_neg_select = w[imrr_pkg::SEL_R2N];
      r.right_amp_one_pos_select = w[imrr_pkg::SEL_R1P];
      r.right_amp_one_neg_select = w[imrr_pkg::SEL_R1N];
      route_from_word = r;
   endfunction

   // connections back to a read word, unused bits zero
   function automatic logic [15:0] route_to_word(
      input imrr_pkg::imrr_route_t r
   );
      logic [15:0] w;
      w = 16'h0000;
      w[imrr_pkg::SEL_L2P] = r.left_amp_two_pos_select;
      w[imrr_pkg::SEL_L2N] = r.left_amp_two_neg_select;
      w[imrr_pkg::SEL_L1P] = r.left_amp_one_pos_select;
      w[imrr_pkg::SEL_L1N] = r.left_amp_one_neg_select;
      w[imrr_pkg::SEL_R2P] = r.right_amp_two_pos_select;
      w[imrr_pkg::SEL_R2N] = r.right_amp_two_neg_select;
      w[imrr_pkg::SEL_R1P] = r.right_amp_one_pos_select;
      w[imrr_pkg::SEL_R1N] = r.right_amp_one_neg_select;
      route_to_word = w & imrr_pkg::SEL_MASK;
   endfunction

   // mixer word to controls; shared by both sides
   function automatic imrr_pkg::imrr_mix_t mix_from_word(
      input logic [15:0] w
   );
      imrr_pkg::imrr_mix_t m;
      m = imrr_pkg::RST_MIX;
      m.amp_two_mix_unmute = w[imrr_pkg::MIX_A2_UNMUTE];
      m.amp_two_mix_boost  = w[imrr_pkg::MIX_A2_BOOST];
      m.amp_one_mix_unmute = w[imrr_pkg::MIX_A1_UNMUTE];
      m.amp_one_mix_boost  = w[imrr_pkg::MIX_A1_BOOST];
      m.feedback_gain      = w[imrr_pkg::MIX_FB_LSB +: imrr_pkg::MIX_FB_W];
      mix_from_word = m;
   endfunction

   // mixer controls back to a read word, bits 6 and 3 stay zero
   function automatic logic [15:0] mix_to_word(
      input imrr_pkg::imrr_mix_t m
   );
      logic [15:0] w;
      w = 16'h0000;
      w[imrr_pkg::MIX_A2_UNMUTE] = m.amp_two_mix_unmute;
      w[imrr_pkg::MIX_A2_BOOST]  = m.amp_two_mix_boost;
      w[imrr_pkg::MIX_A1_UNMUTE] = m.amp_one_mix_unmute;
      w[imrr_pkg::MIX_A1_BOOST]  = m.amp_one_mix_boost;
      w[imrr_pkg::MIX_FB_LSB +: imrr_pkg::MIX_FB_W] = m.feedback_gain;
      mix_to_word = w & imrr_pkg::MIX_MASK;
   endfunction

   // an unmuted amp whose positive input sits on mid-rail
   function automatic logic side_ref_need(
      input imrr_pkg::imrr_mix_t m,
      input logic                two_pos,
      input logic                one_pos
   );
      side_ref_need = (m.amp_two_mix_unmute & ~two_pos)
                    | (m.amp_one_mix_unmute & ~one_pos);
   endfunction

   // ------------
   // state
   // ------------
   imrr_pkg::imrr_state_t state_r;
   imrr_pkg::imrr_state_t state_nxt;
   imrr_pkg::imrr_state_t rst_state;

   // reset image: everything disconnected or muted
   always_comb begin
      rst_state          = state_r;
      rst_state.route    = imrr_pkg::RST_ROUTE;
      rst_state.lmix     = imrr_pkg::RST_MIX;
      rst_state.rmix     = imrr_pkg::RST_MIX;
      rst_state.lfb_mute = imrr_pkg::RST_FB_MUTE;
      rst_state.rfb_mute = imrr_pkg::RST_FB_MUTE;
      rst_state.ref_need = imrr_pkg::RST_REF;
      rst_state.rdata    = imrr_pkg::RST_RDATA;
   end

   // next state: writes, read capture, derived flags
   always_comb begin
      state_nxt       = state_r;
      // read data stands for one cycle only
      state_nxt.rdata = imrr_pkg::RST_RDATA;
      if (reg_wr) begin
         if (hit(reg_addr, imrr_pkg::OFS_PIN_SEL)) begin
            state_nxt.route = route_from_word(reg_wdata);
         end
         if (hit(reg_addr, imrr_pkg::OFS_LMIX)) begin
            state_nxt.lmix = mix_from_word(reg_wdata);
         end
         if (hit(reg_addr, imrr_pkg::OFS_RMIX)) begin
            state_nxt.rmix = mix_from_word(reg_wdata);
         end
      end
      // unmapped addresses answer zero
      if (reg_rd) begin
         if (hit(reg_addr, imrr_pkg::OFS_PIN_SEL)) begin
            state_nxt.rdata = route_to_word(state_r.route);
         end else if (hit(reg_addr, imrr_pkg::OFS_LMIX)) begin
            state_nxt.rdata = mix_to_word(state_r.lmix);
         end else if (hit(reg_addr, imrr_pkg::OFS_RMIX)) begin
            state_nxt.rdata = mix_to_word(state_r.rmix);
         end
      end
      // decoded from the new fields so they never lag a write
      state_nxt.lfb_mute = (state_nxt.lmix.feedback_gain == imrr_pkg::FB_MUTE);
      state_nxt.rfb_mute = (state_nxt.rmix.feedback_gain == imrr_pkg::FB_MUTE);
      // status only: the buffer itself is software's job
      state_nxt.ref_need =
         side_ref_need(state_nxt.lmix,
                       state_nxt.route.left_amp_two_pos_select,
                       state_nxt.route.left_amp_one_pos_select)
       | side_ref_need(state_nxt.rmix,
                       state_nxt.route.right_amp_two_pos_select,
                       state_nxt.route.right_amp_one_pos_select);
   end

   // reset beats the enable; a low enable freezes everything
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_r <= rst_state;
      end else if (core_ce) begin
         state_r <= state_nxt;
      end
   end

   // ------------
   // outputs, all straight from state flops
   // ------------
   assign reg_rdata               = state_r.rdata;
   assign amp_route               = state_r.route;
   assign left_record_mixer       = state_r.lmix;
   assign right_record_mixer      = state_r.rmix;
   assign left_feedback_mute      = state_r.lfb_mute;
   assign right_feedback_mute     = state_r.rfb_mute;
   assign reference_buffer_needed = state_r.ref_need;

   // ------------
   // checks
   // ------------

   // pin select write lands in the routing outputs
   AST_ROUTE_WR: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && reg_wr && hit(reg_addr, imrr_pkg::OFS_PIN_SEL)
      |=> amp_route == $past(reg_wdata[7:0]))
      else $error("routing does not follow pin select write");

   // left mixer write lands, reserved bits dropped
   AST_LMIX_WR: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && reg_wr && hit(reg_addr, imrr_pkg::OFS_LMIX)
      |=> left_record_mixer == {$past(reg_wdata[8:7]), $past(reg_wdata[5:4]), $past(reg_wdata[2:0])})
      else $error("left mixer controls do not follow write");

   // right mixer write lands, reserved bits dropped
   AST_RMIX_WR: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && reg_wr && hit(reg_addr, imrr_pkg::OFS_RMIX)
      |=> right_record_mixer == {$past(reg_wdata[8:7]), $past(reg_wdata[5:4]), $past(reg_wdata[2:0])})
      else $error("right mixer controls do not follow write");

   // two cycles without a write, then held on the next cycle
   AST_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
      !(core_ce && reg_wr) ##1 !(core_ce && reg_wr)
      |=> $stable(amp_route) && $stable(left_record_mixer) && $stable(right_record_mixer))
      else $error("controls changed without a write");

   // pin select read returns stored value, upper byte zero
   AST_RD_SEL: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && reg_rd && hit(reg_addr, imrr_pkg::OFS_PIN_SEL)
      |=> reg_rdata == {8'h00, $past(amp_route)})
      else $error("pin select readback wrong");

   // left mixer read returns stored value with reserved bits zero
   AST_RD_LMIX: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && reg_rd && hit(reg_addr, imrr_pkg::OFS_LMIX)
      |=> reg_rdata == mix_to_word($past(left_record_mixer))
          && (reg_rdata & ~imrr_pkg::MIX_MASK) == 16'h0000)
      else $error("left mixer readback wrong");

   // read data stand one cycle only
   AST_RD_ONE: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outstayed its cycle");

   // first cycle after reset: all muted and disconnected
   AST_RESET: assert property (@(posedge core_clk) disable iff (sys_rst)
      $past(sys_rst) |-> amp_route == 8'h00 && left_record_mixer == 7'h00
         && right_record_mixer == 7'h00 && left_feedback_mute && right_feedback_mute)
      else $error("bad state after reset");

   // feedback mute flags track code 000
   AST_FB_MUTE: assert property (@(posedge core_clk) disable iff (sys_rst)
      left_feedback_mute == (left_record_mixer.feedback_gain == 3'h0)
      && right_feedback_mute == (right_record_mixer.feedback_gain == 3'h0))
      else $error("feedback mute flag disagrees with gain code");

   // reference status tracks unmuted mid-rail amps
   AST_REF_NEED: assert property (@(posedge core_clk) disable iff (sys_rst)
      reference_buffer_needed ==
        ((left_record_mixer.amp_two_mix_unmute && !amp_route.left_amp_two_pos_select)
      || (left_record_mixer.amp_one_mix_unmute && !amp_route.left_amp_one_pos_select)
      || (right_record_mixer.amp_two_mix_unmute && !amp_route.right_amp_two_pos_select)
      || (right_record_mixer.amp_one_mix_unmute && !amp_route.right_amp_one_pos_select)))
      else $error("reference status wrong");

   // low enable freezes the read data too
   AST_CE_FREEZE: assert property (@(posedge core_clk) disable iff (sys_rst)
      !core_ce |=> $stable(reg_rdata) && $stable(amp_route))
      else $error("state moved with enable low");

   // right mixer readback, reserved bits zero
   AST_RD_RMIX: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && reg_rd && hit(reg_addr, imrr_pkg::OFS_RMIX)
      |=> reg_rdata == {7'h00, $past(right_record_mixer[6:5]), 1'b0,
                        $past(right_record_mixer[4:3]), 1'b0, $past(right_record_mixer[2:0])})
      else $error("right mixer readback wrong");

   // other addresses read as zero
   AST_RD_UNMAPPED: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && reg_rd && !mapped(reg_addr)
      |=> reg_rdata == 16'h0000)
      else $error("unmapped read returned data");

   // other addresses take no write
   AST_WR_UNMAPPED: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && reg_wr && !mapped(reg_addr)
      |=> $stable(amp_route) && $stable(left_record_mixer) && $stable(right_record_mixer))
      else $error("unmapped write changed a control");

   // a pin select write leaves both mixers alone
   AST_SEL_ONLY: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && reg_wr && hit(reg_addr, imrr_pkg::OFS_PIN_SEL)
      |=> $stable(left_record_mixer) && $stable(right_record_mixer))
      else $error("pin select write touched a mixer");

   // a left mixer write leaves routing and right mixer alone
   AST_LMIX_ONLY: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && reg_wr && hit(reg_addr, imrr_pkg::OFS_LMIX)
      |=> $stable(amp_route) && $stable(right_record_mixer))
      else $error("left mixer write touched another register");

   // a right mixer write leaves routing and left mixer alone
   AST_RMIX_ONLY: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && reg_wr && hit(reg_addr, imrr_pkg::OFS_RMIX)
      |=> $stable(amp_route) && $stable(left_record_mixer))
      else $error("right mixer write touched another register");

   // reads have no side effect on the controls
   AST_RD_NO_SIDE: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && reg_rd
      |=> $stable(amp_route) && $stable(left_record_mixer) && $stable(right_record_mixer))
      else $error("read changed a control");

   // read data and reference status clear in reset
   AST_RESET_STATUS: assert property (@(posedge core_clk) disable iff (sys_rst)
      $past(sys_rst)
      |-> reg_rdata == 16'h0000 && !reference_buffer_needed)
      else $error("status not clear after reset");

   // low enable freezes mixers and status as well
   AST_CE_HOLD_MIX: assert property (@(posedge core_clk) disable iff (sys_rst)
      !core_ce |=> $stable(left_record_mixer) && $stable(right_record_mixer)
         && $stable(reference_buffer_needed))
      else $error("mixer state moved with enable low");

   // left feedback mute follows the written code
   AST_LFB_WR: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && reg_wr && hit(reg_addr, imrr_pkg::OFS_LMIX)
      |=> left_feedback_mute == ($past(reg_wdata[2:0]) == 3'h0))
      else $error("left feedback mute wrong after write");

   // right feedback mute follows the written code
   AST_RFB_WR: assert property (@(posedge core_clk) disable iff (sys_rst)
      core_ce && reg_wr && hit(reg_addr, imrr_pkg::OFS_RMIX)
      |=> right_feedback_mute == ($past(reg_wdata[2:0]) == 3'h0))
      else $error("right feedback mute wrong after write");

   // every positive input on its pin: no reference needed
   AST_REF_PINS: assert property (@(posedge core_clk) disable iff (sys_rst)
      (amp_route & 8'hAA) == 8'hAA
      |-> !reference_buffer_needed)
      else $error("reference flagged with all pins selected");

   // every amp muted: no reference needed
   AST_REF_MUTED: assert property (@(posedge core_clk) disable iff (sys_rst)
      !left_record_mixer.amp_two_mix_unmute && !left_record_mixer.amp_one_mix_unmute
      && !right_record_mixer.amp_two_mix_unmute && !right_record_mixer.amp_one_mix_unmute
      |-> !reference_buffer_needed)
      else $error("reference flagged with all amps muted");

endmodule

/* File: tb/imrr_regs_tb_top.sv */
// self-checking testbench for the input mixer routing register bank
`timescale 1ns/1ns

module imrr_regs_tb_top;

   // ------------
   // signals
   // ------------
   logic                        core_clk;
   logic                        sys_rst;
   logic                        core_ce;
   logic [imrr_pkg::ADDR_W-1:0] reg_addr;
   logic [15:0]                 reg_wdata;
   logic                        reg_wr;
   logic                        reg_rd;
   logic [15:0]                 reg_rdata;
   imrr_pkg::imrr_route_t       amp_route;
   imrr_pkg::imrr_mix_t         left_record_mixer;
   imrr_pkg::imrr_mix_t         right_record_mixer;
   logic                        left_feedback_mute;
   logic                        right_feedback_mute;
   logic                        reference_buffer_needed;
   int                          n_errors;
   int                          checks_done;

   imrr_regs i_dut (
      .core_clk                (core_clk),
      .sys_rst                 (sys_rst),
      .core_ce                 (core_ce),
      .reg_addr                (reg_addr),
      .reg_wdata               (reg_wdata),
      .reg_wr                  (reg_wr),
      .reg_rd                  (reg_rd),
      .reg_rdata               (reg_rdata),
      .amp_route               (amp_route),
      .left_record_mixer       (left_record_mixer),
      .right_record_mixer      (right_record_mixer),
      .left_feedback_mute      (left_feedback_mute),
      .right_feedback_mute     (right_feedback_mute),
      .reference_buffer_needed (reference_buffer_needed)
   );

   // ------------
   // helpers
   // ------------
   // 125 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // one-cycle write strobe; outputs are settled on return, 1 ns after the capturing edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // read strobe, then compare the data in the one cycle it stands, then expect zero
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check("rdata", reg_rdata, exp);
      @(posedge core_clk);
      #1;
      check("rdata_idle", reg_rdata, 16'h0000);
   endtask

   // expected mixer output from a register word: bits 8,7,5,4 and 2:0
   function automatic logic [15:0] mixw(input logic [15:0] w);
      return {9'h000, w[8], w[7], w[5], w[4], w[2:0]};
   endfunction

   function automatic logic [15:0] mix_out(input logic [7:0] a);
      return (a == imrr_pkg::OFS_LMIX) ? {9'h000, left_record_mixer} : {9'h000, right_record_mixer};
   endfunction

   function automatic logic [15:0] mute_out(input logic [7:0] a);
      return (a == imrr_pkg::OFS_LMIX) ? {15'h0000, left_feedback_mute} : {15'h0000, right_feedback_mute};
   endfunction

   // ------------
   // scenarios
   // ------------
   // everything disconnected or muted out of reset
   task automatic t_reset_state;
      check("route", {8'h00, amp_route}, 16'h0000);
      check("lmix", {9'h000, left_record_mixer}, 16'h0000);
      check("rmix", {9'h000, right_record_mixer}, 16'h0000);
      check("fbmute", {14'h0000, left_feedback_mute, right_feedback_mute}, 16'h0003);
      check("refneed", {15'h0000, reference_buffer_needed}, 16'h0000);
      rd(imrr_pkg::OFS_PIN_SEL, 16'h0000);
      rd(imrr_pkg::OFS_LMIX, 16'h0000);
      rd(imrr_pkg::OFS_RMIX, 16'h0000);
   endtask

   // walking one over each pin select, then all ones to expose unassigned bits
   task automatic t_route;
      for (int i = 0; i < 8; i++) begin
         wr(imrr_pkg::OFS_PIN_SEL, 16'h0001 << i);
         check("route", {8'h00, amp_route}, 16'h0001 << i);
         rd(imrr_pkg::OFS_PIN_SEL, 16'h0001 << i);
      end
      wr(imrr_pkg::OFS_PIN_SEL, 16'hFFFF);
      check("route_all", {8'h00, amp_route}, 16'h00FF);
      rd(imrr_pkg::OFS_PIN_SEL, 16'h00FF);
   endtask

   // single mute and boost bits per mixer, then all ones
   task automatic t_mix;
      logic [7:0] a;
      logic [3:0] pos [4];
      pos = '{4'h8, 4'h7, 4'h5, 4'h4};
      for (int s = 0; s < 2; s++) begin
         a = (s == 0) ? imrr_pkg::OFS_LMIX : imrr_pkg::OFS_RMIX;
         for (int b = 0; b < 4; b++) begin
            wr(a, 16'h0001 << pos[b]);
            check("mix_bit", mix_out(a), mixw(16'h0001 << pos[b]));
         end
         wr(a, 16'hFFFF);
         check("mix_all", mix_out(a), 16'h007F);
         rd(a, 16'h01B7);
      end
   endtask

   // every feedback code on both sides; only 000 mutes
   task automatic t_feedback;
      logic [7:0] a;
      for (int s = 0; s < 2; s++) begin
         a = (s == 0) ? imrr_pkg::OFS_LMIX : imrr_pkg::OFS_RMIX;
         for (int c = 0; c < 8; c++) begin
            wr(a, 16'(c));
            check("fb_gain", mix_out(a), 16'(c));
            check("fb_mute", mute_out(a), (c == 0) ? 16'h0001 : 16'h0000);
         end
         rd(a, 16'h0007);
      end
   endtask

   // neighbouring address takes no write and reads zero
   task automatic t_unmapped;
      wr(imrr_pkg::OFS_LMIX, 16'h0120);
      wr(8'h2B, 16'hFFFF);
      rd(8'h2B, 16'h0000);
      check("lmix_kept", {9'h000, left_record_mixer}, mixw(16'h0120));
   endtask

   // write then read with no gap returns the new word
   task automatic t_back_to_back;
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= imrr_pkg::OFS_RMIX;
      reg_wdata <= 16'h0095;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check("b2b_rdata", reg_rdata, 16'h0095);
   endtask

   // an unmuted amp whose positive input sits at mid-rail needs the reference buffer
   task automatic t_reference;
      wr(imrr_pkg::OFS_PIN_SEL, 16'h0000);
      wr(imrr_pkg::OFS_RMIX, 16'h0000);
      wr(imrr_pkg::OFS_LMIX, 16'h0100);
      @(posedge core_clk);
      #1;
      check("ref_on", {15'h0000, reference_buffer_needed}, 16'h0001);
      wr(imrr_pkg::OFS_PIN_SEL, 16'h0080);
      @(posedge core_clk);
      #1;
      check("ref_off", {15'h0000, reference_buffer_needed}, 16'h0000);
      wr(imrr_pkg::OFS_RMIX, 16'h0020);
      check("ref_right_on", {15'h0000, reference_buffer_needed}, 16'h0001);
      wr(imrr_pkg::OFS_PIN_SEL, 16'h0082);
      check("ref_right_off", {15'h0000, reference_buffer_needed}, 16'h0000);
   endtask

   // a low enable freezes read data and ignores a write strobe
   task automatic t_clock_enable;
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= imrr_pkg::OFS_LMIX;
      @(posedge core_clk);
      reg_rd  <= 1'b0;
      core_ce <= 1'b0;
      wr(imrr_pkg::OFS_LMIX, 16'h0010);
      check("ce_rdata", reg_rdata, 16'h0100);
      check("ce_hold", {9'h000, left_record_mixer}, mixw(16'h0100));
      @(posedge core_clk);
      core_ce <= 1'b1;
   endtask

   // a reset in mid-run clears every field and sets both feedback mutes
   task automatic t_mid_reset;
      wr(imrr_pkg::OFS_RMIX, 16'h01B7);
      @(posedge core_clk);
      sys_rst <= 1'b1;
      @(posedge core_clk);
      sys_rst <= 1'b0;
      #1;
      t_reset_state();
   endtask

   // ------------
   // main sequence and watchdog
   // ------------
   initial begin
      n_errors    = 0;
      checks_done = 0;
      sys_rst     = 1'b1;
      core_ce     = 1'b1;
      reg_addr    = '0;
      reg_wdata   = 16'h0000;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      #1;
      t_reset_state();
      t_route();
      t_mix();
      t_feedback();
      t_unmapped();
      t_back_to_back();
      t_reference();
      t_clock_enable();
      t_mid_reset();
      report_and_stop();
   end

   // bounded run: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      report_and_stop();
   end

endmodule
